// *** tlbm_cfg.svh ***
// Constants for the translation-buffer maintenance block
`ifndef TLBM_CFG_SVH
`define TLBM_CFG_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define TLBM_PRIMARY_OP 6'h1f
`define TLBM_XO_LOAD_DATA 10'h3d2
`define TLBM_XO_LOAD_INSTR 10'h3f2
`define TLBM_XO_INVAL_ENTRY 10'h132
`define TLBM_XO_INVAL_ALL 10'h172
`define TLBM_XO_SYNC 10'h236
`define TLBM_XO_BLK_FLUSH 10'h056
`define TLBM_XO_BLK_INVAL 10'h1d6
`define TLBM_XO_MFSR 10'h253
`define TLBM_XO_MFSRIN 10'h293
`define TLBM_XO_MTSR 10'h0d2
`define TLBM_XO_MTSRIN 10'h0f2
`define TLBM_XO_MFSPR 10'h153
`define TLBM_XO_MTSPR 10'h1d3

// ----------------------------------------------------------------
// Special-register numbers of the staging registers
// ----------------------------------------------------------------
`define TLBM_SPR_DATA_PTE_COMPARE_REG_NUM 10'h3d1
`define TLBM_SPR_INSTR_PTE_COMPARE_REG_NUM 10'h3d5
`define TLBM_SPR_RPA_NUM 10'h3d6

// ----------------------------------------------------------------
// Field positions (bit 0 of the architecture is bit 31 here)
// ----------------------------------------------------------------
`define TLBM_EA_IDX_HI 16
`define TLBM_EA_IDX_LO 12
`define TLBM_SR_SEL_HI 31
`define TLBM_SR_SEL_LO 28

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TLBM_STAGE_RST 32'h0000_0000

`endif

// *** tlbm_pkg.sv ***
// Types for the translation-buffer maintenance block
package tlbm_pkg;
   // Decoded operation
   typedef enum logic [3:0] {
      TLBM_OP_NONE, TLBM_OP_LDD, TLBM_OP_LDI, TLBM_OP_INV, TLBM_OP_FLUSH,
      TLBM_OP_MFSR, TLBM_OP_MTSR, TLBM_OP_MFSPR, TLBM_OP_MTSPR, TLBM_OP_ILL
   } tlbm_op_t;
   // Sequencer states
   typedef enum logic [1:0] {TLBM_IDLE, TLBM_SR_RD, TLBM_FL_INV} tlbm_state_t;
endpackage

// *** tlbm_mem.sv ***
// Single-port-write, registered-read storage array
`timescale 1ns/1ps
`default_nettype none
module tlbm_mem #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic core_clk_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [WIDTH-1:0] wdata_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [WIDTH-1:0] rdata_o
);
   // Storage words
   logic [WIDTH-1:0] mem_ff [DEPTH];

   // Write port
   always_ff @(posedge core_clk_i) begin
      if (we_i) begin
         mem_ff[waddr_i] <= wdata_i;
      end
   end

   // Registered read port
   always_ff @(posedge core_clk_i) begin
      rdata_o <= mem_ff[raddr_i];
   end
endmodule
`default_nettype wire

// *** tlbm_core.sv ***
// Memory-control instruction unit: translation buffers and segment registers
//
// Notes on behaviour
// - Block flush writes modified block back first.
// - Four segment moves: direct and indirect, read/write.
// - Segment moves ignore translation enable bits.
// - Sixteen on-chip segment registers hold descriptors.
// - Entry invalidate index is address bits 15-19.
// - Invalidate clears both sets in both buffers.
// - Invalidate-all instruction is not implemented.
// - Two entry-load instructions for miss handlers.
// - Data entry load is opcode 31/978.
// - Instruction entry load is opcode 31/1010.
// - Data load writes compare plus physical address.
// - Entry chosen by address index and way bit.
// - Instruction load writes compare plus physical address.
// - Entry loads are privileged, supervisor only.
// - Staging registers at special numbers 977/981/982.
`timescale 1ns/1ps
`default_nettype none
`include "tlbm_cfg.svh"
module tlbm_core
   import tlbm_pkg::*;
#(
   parameter int IDX_W = 5,
   parameter int NUM_SR = 16
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic issue_i,
   input wire logic [31:0] instr_i,
   input wire logic [31:0] rs_val_i,
   input wire logic [31:0] rb_val_i,
   input wire logic supervisor_i,
   input wire logic instr_translate_enable_i,
   input wire logic data_translate_enable_i,
   input wire logic save_restore_one_way_i,
   input wire logic lookup_i,
   input wire logic lookup_instr_i,
   input wire logic lookup_way_i,
   input wire logic [IDX_W-1:0] lookup_idx_i,
   output logic done_o,
   output logic gpr_we_o,
   output logic [4:0] gpr_idx_o,
   output logic [31:0] gpr_data_o,
   output logic illegal_o,
   output logic priv_fault_o,
   output logic blk_wb_req_o,
   output logic blk_inv_req_o,
   output logic [31:0] blk_addr_o,
   output logic lookup_valid_o,
   output logic lookup_hit_o,
   output logic [63:0] lookup_entry_o
);
   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   localparam int TLB_AW = IDX_W + 2;
   localparam int SR_AW = $clog2(NUM_SR);

   // Maps the instruction word to an operation
   function automatic tlbm_op_t decode(input logic [31:0] ins);
      tlbm_op_t op;
      op = TLBM_OP_NONE;
      if (ins[31:26] == `TLBM_PRIMARY_OP) begin
         unique case (ins[10:1])
            // Reserved fields must be zero on the loads
            `TLBM_XO_LOAD_DATA: op = (ins[25:16] == 10'h000 && !ins[0]) ? TLBM_OP_LDD
                                                                     : TLBM_OP_ILL;
            `TLBM_XO_LOAD_INSTR: op = (ins[25:16] == 10'h000 && !ins[0]) ? TLBM_OP_LDI
                                                                      : TLBM_OP_ILL;
            `TLBM_XO_INVAL_ENTRY: op = TLBM_OP_INV;
            `TLBM_XO_INVAL_ALL: op = TLBM_OP_ILL;
            `TLBM_XO_BLK_INVAL: op = TLBM_OP_ILL;
            `TLBM_XO_BLK_FLUSH: op = TLBM_OP_FLUSH;
            `TLBM_XO_MFSR, `TLBM_XO_MFSRIN: op = TLBM_OP_MFSR;
            `TLBM_XO_MTSR, `TLBM_XO_MTSRIN: op = TLBM_OP_MTSR;
            `TLBM_XO_MFSPR: op = TLBM_OP_MFSPR;
            `TLBM_XO_MTSPR: op = TLBM_OP_MTSPR;
            default: op = TLBM_OP_NONE;
         endcase
      end
      return op;
   endfunction

   // Special-register number with its two halves swapped back
   function automatic logic [9:0] spr_num(input logic [31:0] ins);
      return {ins[15:11], ins[20:16]};
   endfunction

   // Checks whether an operation is a staging register access we own
   function automatic logic spr_ours(input logic [9:0] num);
      return num == `TLBM_SPR_DATA_PTE_COMPARE_REG_NUM || num == `TLBM_SPR_INSTR_PTE_COMPARE_REG_NUM ||
             num == `TLBM_SPR_RPA_NUM;
   endfunction

   tlbm_op_t op; // Decoded operation of the issued word
   logic is_priv; // Operation needs supervisor state
   logic [IDX_W-1:0] ea_idx; // Index field of the effective address
   logic [SR_AW-1:0] sr_sel; // Selected segment register
   logic go; // Accepted operation this cycle
   logic [9:0] spr; // Special-register number

   always_comb begin
      op = issue_i ? decode(instr_i) : TLBM_OP_NONE;
      spr = spr_num(instr_i);
      if ((op == TLBM_OP_MFSPR || op == TLBM_OP_MTSPR) && !spr_ours(spr)) begin
         op = TLBM_OP_NONE;
      end
      is_priv = op != TLBM_OP_FLUSH && op != TLBM_OP_NONE && op != TLBM_OP_ILL;
      ea_idx = rb_val_i[`TLBM_EA_IDX_HI:`TLBM_EA_IDX_LO];
      // Direct form names the register in the instruction, indirect in rB
      sr_sel = (instr_i[10:1] == `TLBM_XO_MFSRIN || instr_i[10:1] == `TLBM_XO_MTSRIN)
               ? rb_val_i[`TLBM_SR_SEL_HI:`TLBM_SR_SEL_LO] : instr_i[19:16];
      go = op != TLBM_OP_NONE && op != TLBM_OP_ILL && (supervisor_i || !is_priv);
   end

   // ----------------------------------------------------------------
   // Staging registers
   // ----------------------------------------------------------------
   logic [31:0] data_pte_compare_reg_ff; // Data entry compare word
   logic [31:0] instr_pte_compare_reg_ff; // Instruction entry compare word
   logic [31:0] required_phys_addr_reg_ff; // Physical address word

   // Written by special-register moves only; entry loads leave them alone
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         data_pte_compare_reg_ff <= `TLBM_STAGE_RST;
         instr_pte_compare_reg_ff <= `TLBM_STAGE_RST;
         required_phys_addr_reg_ff <= `TLBM_STAGE_RST;
      end else if (go && op == TLBM_OP_MTSPR) begin
         unique case (spr)
            `TLBM_SPR_DATA_PTE_COMPARE_REG_NUM: data_pte_compare_reg_ff <= rs_val_i;
            `TLBM_SPR_INSTR_PTE_COMPARE_REG_NUM: instr_pte_compare_reg_ff <= rs_val_i;
            default: required_phys_addr_reg_ff <= rs_val_i;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Translation buffer storage and valid bits
   // ----------------------------------------------------------------
   logic tlb_we; // Entry load write strobe
   logic [TLB_AW-1:0] tlb_waddr; // {instr buffer, way, index}
   logic [63:0] tlb_wdata; // Compare word over physical word
   logic [63:0] tlb_rdata; // Registered lookup word
   logic [(1<<TLB_AW)-1:0] valid_ff; // One valid bit per entry

   always_comb begin
      tlb_we = go && (op == TLBM_OP_LDD || op == TLBM_OP_LDI);
      tlb_waddr = {op == TLBM_OP_LDI, save_restore_one_way_i, ea_idx};
      tlb_wdata = {(op == TLBM_OP_LDI) ? instr_pte_compare_reg_ff
                                       : data_pte_compare_reg_ff,
                   required_phys_addr_reg_ff};
   end

   tlbm_mem #(.WIDTH(64), .DEPTH(1 << TLB_AW)) u_tlb_mem (
      .core_clk_i(core_clk_i),
      .we_i(tlb_we),
      .waddr_i(tlb_waddr),
      .wdata_i(tlb_wdata),
      .raddr_i({lookup_instr_i, lookup_way_i, lookup_idx_i}),
      .rdata_o(tlb_rdata)
   );

   // Load sets one entry valid; invalidate clears four at one index
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         valid_ff <= '0;
      end else begin
         for (int b = 0; b < 4; b++) begin
            if (go && op == TLBM_OP_INV) begin
               valid_ff[{b[1:0], ea_idx}] <= 1'b0;
            end
         end
         if (tlb_we) begin
            valid_ff[tlb_waddr] <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Lookup port
   // ----------------------------------------------------------------
   logic lookup_d_ff; // Lookup issued last cycle
   logic lookup_vbit_ff; // Valid bit sampled with the read

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         lookup_d_ff <= 1'b0;
         lookup_vbit_ff <= 1'b0;
         lookup_valid_o <= 1'b0;
         lookup_hit_o <= 1'b0;
         lookup_entry_o <= '0;
      end else begin
         lookup_d_ff <= lookup_i;
         lookup_vbit_ff <= valid_ff[{lookup_instr_i, lookup_way_i, lookup_idx_i}];
         lookup_valid_o <= lookup_d_ff;
         if (lookup_d_ff) begin
            lookup_hit_o <= lookup_vbit_ff;
            lookup_entry_o <= tlb_rdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Segment registers
   // ----------------------------------------------------------------
   logic [31:0] sr_rdata; // Registered segment read word

   // Same path whatever the translation enables say
   tlbm_mem #(.WIDTH(32), .DEPTH(NUM_SR)) u_sr_mem (
      .core_clk_i(core_clk_i),
      .we_i(go && op == TLBM_OP_MTSR),
      .waddr_i(sr_sel),
      .wdata_i(rs_val_i),
      .raddr_i(sr_sel),
      .rdata_o(sr_rdata)
   );

   // ----------------------------------------------------------------
   // Sequencer and result outputs
   // ----------------------------------------------------------------
   tlbm_state_t state_ff; // Multi-cycle operation state
   logic [4:0] dest_ff; // Destination register held over a read

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_ff <= TLBM_IDLE;
         dest_ff <= '0;
         done_o <= 1'b0;
         gpr_we_o <= 1'b0;
         gpr_idx_o <= '0;
         gpr_data_o <= '0;
         illegal_o <= 1'b0;
         priv_fault_o <= 1'b0;
         blk_wb_req_o <= 1'b0;
         blk_inv_req_o <= 1'b0;
         blk_addr_o <= '0;
      end else begin
         done_o <= 1'b0;
         gpr_we_o <= 1'b0;
         illegal_o <= 1'b0;
         priv_fault_o <= 1'b0;
         blk_wb_req_o <= 1'b0;
         blk_inv_req_o <= 1'b0;
         unique case (state_ff)
            TLBM_IDLE: begin
               if (op == TLBM_OP_ILL) begin
                  // Unimplemented forms raise an illegal-instruction fault
                  illegal_o <= 1'b1;
                  done_o <= 1'b1;
               end else if (op != TLBM_OP_NONE && !go) begin
                  priv_fault_o <= 1'b1;
                  done_o <= 1'b1;
               end else if (go && op == TLBM_OP_MFSR) begin
                  dest_ff <= instr_i[25:21];
                  state_ff <= TLBM_SR_RD;
               end else if (go && op == TLBM_OP_FLUSH) begin
                  // Write-back goes out before the invalidate
                  blk_wb_req_o <= 1'b1;
                  blk_addr_o <= rb_val_i;
                  state_ff <= TLBM_FL_INV;
               end else if (go && op == TLBM_OP_MFSPR) begin
                  gpr_we_o <= 1'b1;
                  gpr_idx_o <= instr_i[25:21];
                  gpr_data_o <= (spr == `TLBM_SPR_DATA_PTE_COMPARE_REG_NUM) ? data_pte_compare_reg_ff :
                                (spr == `TLBM_SPR_INSTR_PTE_COMPARE_REG_NUM) ? instr_pte_compare_reg_ff :
                                required_phys_addr_reg_ff;
                  done_o <= 1'b1;
               end else if (go) begin
                  // Loads, invalidates and moves-to end here, no register write
                  done_o <= 1'b1;
               end
            end
            TLBM_SR_RD: begin
               gpr_we_o <= 1'b1;
               gpr_idx_o <= dest_ff;
               gpr_data_o <= sr_rdata;
               done_o <= 1'b1;
               state_ff <= TLBM_IDLE;
            end
            TLBM_FL_INV: begin
               blk_inv_req_o <= 1'b1;
               done_o <= 1'b1;
               state_ff <= TLBM_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_flush_order;
      @(posedge core_clk_i) disable iff (rst_i)
      blk_wb_req_o |=> blk_inv_req_o;
   endproperty
   a_flush_order: assert property (p_flush_order) else $error("flush without invalidate");

   property p_inv_after_wb;
      @(posedge core_clk_i) disable iff (rst_i)
      blk_inv_req_o |-> $past(blk_wb_req_o);
   endproperty
   a_inv_after_wb: assert property (p_inv_after_wb) else $error("invalidate before write-back");

   property p_sr_read;
      @(posedge core_clk_i) disable iff (rst_i)
      (go && op == TLBM_OP_MFSR) |=> ##1 (gpr_we_o && done_o);
   endproperty
   a_sr_read: assert property (p_sr_read) else $error("segment read not returned");

   property p_inv_four;
      @(posedge core_clk_i) disable iff (rst_i)
      (go && op == TLBM_OP_INV) |=> ({valid_ff[{2'b00, $past(ea_idx)}],
         valid_ff[{2'b01, $past(ea_idx)}], valid_ff[{2'b10, $past(ea_idx)}],
         valid_ff[{2'b11, $past(ea_idx)}]} == 4'h0);
   endproperty
   a_inv_four: assert property (p_inv_four) else $error("indexed entries still valid");

   property p_load_valid;
      @(posedge core_clk_i) disable iff (rst_i)
      tlb_we |=> valid_ff[$past(tlb_waddr)];
   endproperty
   a_load_valid: assert property (p_load_valid) else $error("loaded entry not valid");

   property p_user_fault;
      @(posedge core_clk_i) disable iff (rst_i)
      (issue_i && !supervisor_i && (op == TLBM_OP_LDD || op == TLBM_OP_LDI)) |=>
         (priv_fault_o && !tlb_we);
   endproperty
   a_user_fault: assert property (p_user_fault) else $error("user entry load not faulted");

   property p_no_gpr_on_load;
      @(posedge core_clk_i) disable iff (rst_i)
      (tlb_we && state_ff == TLBM_IDLE) |=> !gpr_we_o;
   endproperty
   a_no_gpr_on_load: assert property (p_no_gpr_on_load) else $error("load wrote a register");

   property p_stage_hold;
      @(posedge core_clk_i) disable iff (rst_i)
      tlb_we |=> $stable(required_phys_addr_reg_ff) && $stable(data_pte_compare_reg_ff) &&
         $stable(instr_pte_compare_reg_ff);
   endproperty
   a_stage_hold: assert property (p_stage_hold) else $error("staging changed by load");

   property p_inval_all_ill;
      @(posedge core_clk_i) disable iff (rst_i)
      (issue_i && instr_i[31:26] == `TLBM_PRIMARY_OP &&
         instr_i[10:1] == `TLBM_XO_INVAL_ALL) |=> illegal_o;
   endproperty
   a_inval_all_ill: assert property (p_inval_all_ill) else $error("invalidate-all accepted");
endmodule
`default_nettype wire

// *** tlbm_core_tb.sv ***
// Self-checking testbench for the translation-buffer maintenance unit
`timescale 1ns/1ps
`default_nettype none
`include "tlbm_cfg.svh"
`define TLBM_TB_CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
$display("Error %s expected %h seen %h", nm, exp, got); end end
module tlbm_core_tb
   import tlbm_pkg::*;
;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic core_clk; // Bench clock, 100 ns period
   logic rst; // Synchronous reset
   logic issue, supervisor, ite, dte, way; // Issue strobe and state bits
   logic [31:0] instr, rs_val, rb_val; // Instruction and operands
   logic lookup, lookup_instr, lookup_way; // Entry observation request
   logic [4:0] lookup_idx;
   logic done, gpr_we, illegal, priv_fault, blk_wb, blk_inv, lk_valid, lk_hit;
   logic [4:0] gpr_idx;
   logic [31:0] gpr_data, blk_addr;
   logic [63:0] lk_entry;
   int errors; // Mismatch count
   int samples_checked; // Comparison count
   logic [9:0] nums [3] = '{`TLBM_SPR_DATA_PTE_COMPARE_REG_NUM, `TLBM_SPR_INSTR_PTE_COMPARE_REG_NUM, `TLBM_SPR_RPA_NUM};
   logic [31:0] vals [3] = '{32'h8000_0a5c, 32'h8011_2233, 32'h0abc_d012};

   // ----------------------------------------------------------------
   // Design instance
   // ----------------------------------------------------------------
   tlbm_core i_tlbm_core (.core_clk_i(core_clk), .rst_i(rst), .issue_i(issue), .instr_i(instr),
      .rs_val_i(rs_val), .rb_val_i(rb_val), .supervisor_i(supervisor),
      .instr_translate_enable_i(ite), .data_translate_enable_i(dte),
      .save_restore_one_way_i(way), .lookup_i(lookup), .lookup_instr_i(lookup_instr),
      .lookup_way_i(lookup_way), .lookup_idx_i(lookup_idx), .done_o(done), .gpr_we_o(gpr_we),
      .gpr_idx_o(gpr_idx), .gpr_data_o(gpr_data), .illegal_o(illegal),
      .priv_fault_o(priv_fault), .blk_wb_req_o(blk_wb), .blk_inv_req_o(blk_inv),
      .blk_addr_o(blk_addr), .lookup_valid_o(lk_valid), .lookup_hit_o(lk_hit),
      .lookup_entry_o(lk_entry));

   // Free-running clock
   always #50 core_clk = ~core_clk;

   // ----------------------------------------------------------------
   // Encoders
   // ----------------------------------------------------------------
   // Primary opcode 31 form with plain register fields
   function automatic logic [31:0] op(input logic [4:0] d, input logic [4:0] a,
                                      input logic [4:0] b, input logic [9:0] xo);
      return {`TLBM_PRIMARY_OP, d, a, b, xo, 1'b0};
   endfunction
   // Special-register move: number halves swapped in the word
   function automatic logic [31:0] sprop(input logic [4:0] d, input logic [9:0] n,
                                         input logic [9:0] xo);
      return {`TLBM_PRIMARY_OP, d, n[4:0], n[9:5], xo, 1'b0};
   endfunction
   // Effective address carrying an entry index
   function automatic logic [31:0] ea(input logic [4:0] ix);
      return {15'h0, ix, 12'h000};
   endfunction
   // Distinct segment descriptor value per register
   function automatic logic [31:0] sv(input int i);
      return 32'h5a00_0000 + 32'h0001_0001 * 32'(i);
   endfunction

   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   // One-cycle issue; returns settled in the answer cycle
   task automatic exec(input logic [31:0] ins, input logic [31:0] rs, input logic [31:0] rb);
      @(posedge core_clk);
      issue <= 1'b1;
      instr <= ins;
      rs_val <= rs;
      rb_val <= rb;
      @(posedge core_clk);
      issue <= 1'b0;
      #1;
   endtask
   // Advance one settled cycle
   task automatic step;
      @(posedge core_clk);
      #1;
   endtask
   // Observe one entry and compare hit and contents
   task automatic look(input logic ib, input logic w, input logic [4:0] ix, input logic h,
                       input logic [63:0] ent);
      @(posedge core_clk);
      lookup <= 1'b1;
      lookup_instr <= ib;
      lookup_way <= w;
      lookup_idx <= ix;
      @(posedge core_clk);
      lookup <= 1'b0;
      step();
      `TLBM_TB_CHK("lookup_valid", 1'b1, lk_valid);
      `TLBM_TB_CHK("lookup_hit", h, lk_hit);
      if (h) begin
         `TLBM_TB_CHK("lookup_entry", ent, lk_entry);
      end
   endtask
   // Entry load into data or instruction buffer
   task automatic load(input logic ib, input logic w, input logic [4:0] ix);
      way <= w;
      ite <= 1'b0;
      dte <= 1'b0;
      exec(op(5'd0, 5'd0, 5'd3, ib ? `TLBM_XO_LOAD_INSTR : `TLBM_XO_LOAD_DATA), 32'h0, ea(ix));
   endtask
   // Staging register read with expected value
   task automatic rd_spr(input logic [9:0] n, input logic [31:0] exp);
      exec(sprop(5'd4, n, `TLBM_XO_MFSPR), 32'h0, 32'h0);
      `TLBM_TB_CHK("spr_we", 1'b1, gpr_we);
      `TLBM_TB_CHK("spr_idx", 5'd4, gpr_idx);
      `TLBM_TB_CHK("spr_data", exp, gpr_data);
   endtask

   // Closing report and verdict
   task automatic results;
      $display("Comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Watchdog against a hung sequence
   initial begin
      #500_000;
      errors++;
      results();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      rst = 1'b1;
      {issue, ite, dte, way, lookup, lookup_instr, lookup_way} = '0;
      supervisor = 1'b1;
      {instr, rs_val, rb_val} = '0;
      lookup_idx = '0;
      errors = 0;
      samples_checked = 0;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      step();
      `TLBM_TB_CHK("done_rst", 1'b0, done);
      // Staging registers reset, then written and read back
      for (int i = 0; i < 3; i++) begin
         rd_spr(nums[i], 32'h0);
         exec(sprop(5'd0, nums[i], `TLBM_XO_MTSPR), vals[i], 32'h0);
         `TLBM_TB_CHK("mtspr_done", 1'b1, done);
         rd_spr(nums[i], vals[i]);
      end
      // Neighbouring number is not a staging register
      exec(sprop(5'd4, 10'h3d2, `TLBM_XO_MFSPR), 32'h0, 32'h0);
      `TLBM_TB_CHK("spr_other", 1'b0, done);
      // Data and instruction entry loads at index and way
      look(1'b0, 1'b1, 5'd5, 1'b0, 64'h0);
      load(1'b0, 1'b1, 5'd5);
      `TLBM_TB_CHK("ldd_done", 1'b1, done);
      look(1'b0, 1'b1, 5'd5, 1'b1, {vals[0], vals[2]});
      look(1'b0, 1'b0, 5'd5, 1'b0, 64'h0);
      look(1'b1, 1'b1, 5'd5, 1'b0, 64'h0);
      look(1'b0, 1'b1, 5'd6, 1'b0, 64'h0);
      load(1'b1, 1'b0, 5'd5);
      `TLBM_TB_CHK("ldi_done", 1'b1, done);
      look(1'b1, 1'b0, 5'd5, 1'b1, {vals[1], vals[2]});
      for (int i = 0; i < 3; i++) begin
         rd_spr(nums[i], vals[i]);
      end
      // User state refuses a data entry load
      supervisor <= 1'b0;
      load(1'b0, 1'b0, 5'd7);
      `TLBM_TB_CHK("priv_fault", 1'b1, priv_fault);
      `TLBM_TB_CHK("priv_done", 1'b1, done);
      supervisor <= 1'b1;
      look(1'b0, 1'b0, 5'd7, 1'b0, 64'h0);
      // Nonzero reserved field on either load
      for (int b = 0; b < 2; b++) begin
         exec(op(5'd1, 5'd0, 5'd3, b ? `TLBM_XO_LOAD_INSTR : `TLBM_XO_LOAD_DATA), 0, ea(5'd8));
         `TLBM_TB_CHK("rsvd_illegal", 1'b1, illegal);
         look(b[0], 1'b0, 5'd8, 1'b0, 64'h0);
      end
      // Indexed invalidate hits both ways of both buffers only
      for (int k = 0; k < 4; k++) begin
         load(k[1], k[0], 5'd9);
      end
      load(1'b0, 1'b0, 5'd10);
      exec(op(5'd0, 5'd0, 5'd3, `TLBM_XO_INVAL_ENTRY), 32'h0, ea(5'd9));
      `TLBM_TB_CHK("inv_done", 1'b1, done);
      for (int k = 0; k < 4; k++) begin
         look(k[1], k[0], 5'd9, 1'b0, 64'h0);
      end
      look(1'b0, 1'b0, 5'd10, 1'b1, {vals[0], vals[2]});
      // Invalidate-all is refused and leaves entries alone
      exec(op(5'd0, 5'd0, 5'd0, `TLBM_XO_INVAL_ALL), 32'h0, 32'h0);
      `TLBM_TB_CHK("inv_all", 1'b1, illegal);
      look(1'b0, 1'b0, 5'd10, 1'b1, {vals[0], vals[2]});
      // Full clear by 32 indexed invalidates
      for (int i = 0; i < 32; i++) begin
         exec(op(5'd0, 5'd0, 5'd3, `TLBM_XO_INVAL_ENTRY), 32'h0, ea(i[4:0]));
      end
      look(1'b0, 1'b0, 5'd10, 1'b0, 64'h0);
      look(1'b1, 1'b0, 5'd5, 1'b0, 64'h0);
      // Block invalidate refused, flush writes back then invalidates
      exec(op(5'd0, 5'd0, 5'd3, `TLBM_XO_BLK_INVAL), 32'h0, 32'h0000_1240);
      `TLBM_TB_CHK("dcbi_illegal", 1'b1, illegal);
      step();
      `TLBM_TB_CHK("dcbi_inv", 1'b0, blk_inv);
      supervisor <= 1'b0;
      exec(op(5'd0, 5'd0, 5'd3, `TLBM_XO_BLK_FLUSH), 32'h0, 32'h1357_9be0);
      `TLBM_TB_CHK("flush_wb", 1'b1, blk_wb);
      `TLBM_TB_CHK("flush_addr", 32'h1357_9be0, blk_addr);
      `TLBM_TB_CHK("flush_early_inv", 1'b0, blk_inv);
      step();
      `TLBM_TB_CHK("flush_inv", 1'b1, blk_inv);
      `TLBM_TB_CHK("flush_done", 1'b1, done);
      supervisor <= 1'b1;
      // All sixteen segment registers, direct and indirect, any enables
      for (int i = 0; i < 16; i++) begin
         ite <= i[0];
         dte <= i[1];
         // Direct forms carry a wrong select in rB, indirect ones a zero field
         exec(op(5'd0, {1'b0, i[0] ? 4'h0 : i[3:0]}, 5'd0,
                 i[0] ? `TLBM_XO_MTSRIN : `TLBM_XO_MTSR), sv(i),
              {i[0] ? i[3:0] : ~i[3:0], 28'h0});
         `TLBM_TB_CHK("mtsr_done", 1'b1, done);
      end
      for (int i = 0; i < 16; i++) begin
         ite <= ~i[0];
         dte <= i[2];
         exec(op(5'd7, {1'b0, i[0] ? i[3:0] : 4'h0}, 5'd0,
                 i[0] ? `TLBM_XO_MFSR : `TLBM_XO_MFSRIN), 32'h0,
              {i[0] ? ~i[3:0] : i[3:0], 28'h0});
         `TLBM_TB_CHK("mfsr_early", 1'b0, gpr_we);
         step();
         `TLBM_TB_CHK("mfsr_idx", 5'd7, gpr_idx);
         `TLBM_TB_CHK("mfsr_data", sv(i), gpr_data);
         `TLBM_TB_CHK("mfsr_done", 1'b1, done);
      end
      results();
   end
endmodule
`default_nettype wire
